// ==== shared/letm_defines.vh ====
// letm_defines.vh: constants of the link error threshold monitor
// assumes inclusion by bare name from rtl files
`ifndef LETM_DEFINES_VH
`define LETM_DEFINES_VH
`define LETM_THRESHOLD 3'h7
`define LETM_CODE_RX 8'h02
`define LETM_CODE_TX 8'h04
`define LETM_CODE_SEL 8'h06
`define LETM_ADDR_W 4
`define LETM_NSTA 16
// selection window of 400 ns at the 4 ns clock
`define LETM_SEL_CYCLES 8'h64
`define LETM_CAUSE_W 3
`define LETM_CNT_RST 3'h0
`define LETM_TMR_RST 8'h00
`define LETM_BYTE_RST 8'h00
`endif

// ==== rtl/letm_monitor.v ====
// letm_monitor.v: per-station consecutive error counters and threshold reports
// assumes event inputs are one-cycle pulses synchronous to i_ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "letm_defines.vh"

// Functional notes
// RULE1 - receive error run reaching seven reports code 002
// RULE2 - seven receive error causes each advance the receive count
// RULE3 - receive report clears the receive counter
// RULE4 - transmit error run reaching seven reports code 004
// RULE5 - four transmit error causes each advance the transmit count
// RULE6 - transmit report clears counter unless station in start states
// RULE7 - seventh selection timeout reports code 006
// RULE8 - selection window times poll or peer response
// RULE9 - select report clears the selection counter
// RULE10 - output code goes in the response type byte
// RULE11 - station address goes in the station address byte
// RULE12 - separate counters for every station address
// RULE13 - error-free event of same class clears that counter
module letm_monitor (
   input wire i_ref_clk,
   input wire i_nrst,
   input wire [`LETM_ADDR_W-1:0] i_rx_station,
   input wire i_rx_ok,
   input wire [6:0] i_rx_err,
   input wire [`LETM_ADDR_W-1:0] i_tx_station,
   input wire i_tx_ok,
   input wire [3:0] i_tx_err,
   input wire i_tx_start_state,
   input wire [`LETM_ADDR_W-1:0] i_sel_station,
   input wire i_sel_begin,
   input wire i_sel_answer,
   output wire o_sel_timeout,
   output reg o_resp_valid,
   output reg [7:0] o_response_type_byte,
   output reg [7:0] o_station_address_byte
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // saturating count step; stays at threshold until cleared
   function [2:0] letm_step;
      input [2:0] cnt;
      begin
         if (cnt == `LETM_THRESHOLD) begin
            letm_step = cnt;
         end else begin
            letm_step = cnt + 3'h1;
         end
      end
   endfunction

   // an error event whose stepped count lands on the threshold
   function letm_at_threshold;
      input err;
      input [2:0] nxt;
      begin
         letm_at_threshold = err && (nxt == `LETM_THRESHOLD);
      end
   endfunction

   // station number widened into the address byte, upper bits zero
   function [7:0] letm_addr_byte;
      input [`LETM_ADDR_W-1:0] sta;
      begin
         letm_addr_byte = {{(8-`LETM_ADDR_W){1'b0}}, sta};
      end
   endfunction

   // per-station counters live in flip-flops, indexed by station
   reg [2:0] rx_cnt_r [0:`LETM_NSTA-1];
   reg [2:0] tx_cnt_r [0:`LETM_NSTA-1];
   reg [2:0] sel_cnt_r [0:`LETM_NSTA-1];
   reg [7:0] sel_tmr_r;
   reg [7:0] sel_tmr_nxt;
   reg sel_run_r;
   reg sel_run_nxt;
   reg [`LETM_ADDR_W-1:0] sel_sta_r;
   reg [`LETM_ADDR_W-1:0] sel_sta_nxt;
   reg resp_valid_nxt;
   reg [7:0] resp_type_nxt;
   reg [7:0] resp_addr_nxt;
   wire rx_any;
   wire tx_any;
   wire [2:0] rx_cnt_nxt;
   wire [2:0] tx_cnt_nxt;
   wire [2:0] sel_cnt_nxt;
   wire rx_hit;
   wire tx_hit;
   wire sel_hit;
   wire sel_last;
   wire sel_clear;
   integer k_rx;
   integer k_tx;
   integer k_sel;

   // ---------------------------------------------------------------
   // selection interval timer
   // ---------------------------------------------------------------
   // one window at a time; a new begin restarts it, so a re-poll before the
   // last window cycle never lets the older window expire against the station
   assign sel_last = sel_run_r && (sel_tmr_r == 8'h01);
   assign o_sel_timeout = sel_last && !i_sel_answer;
   // an answer clears the count only while a window is open
   assign sel_clear = sel_run_r && i_sel_answer;

   always @* begin
      sel_run_nxt = sel_run_r;
      sel_tmr_nxt = sel_tmr_r;
      sel_sta_nxt = sel_sta_r;
      if (i_sel_begin) begin
         sel_run_nxt = 1'b1; // RULE8
         sel_tmr_nxt = `LETM_SEL_CYCLES;
         sel_sta_nxt = i_sel_station;
      end else if (i_sel_answer || o_sel_timeout) begin
         sel_run_nxt = 1'b0;
      end else if (sel_run_r) begin
         sel_tmr_nxt = sel_tmr_r - 8'h01;
      end
   end

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_run_r <= 1'b0;
         sel_tmr_r <= `LETM_TMR_RST;
         sel_sta_r <= {`LETM_ADDR_W{1'b0}};
      end else begin
         sel_run_r <= sel_run_nxt;
         sel_tmr_r <= sel_tmr_nxt;
         sel_sta_r <= sel_sta_nxt;
      end
   end

   // ---------------------------------------------------------------
   // counters
   // ---------------------------------------------------------------
   // any cause bit counts one error, however many are set
   assign rx_any = |i_rx_err; // RULE2
   assign tx_any = |i_tx_err; // RULE5
   assign rx_cnt_nxt = letm_step(rx_cnt_r[i_rx_station]);
   assign tx_cnt_nxt = letm_step(tx_cnt_r[i_tx_station]);
   assign sel_cnt_nxt = letm_step(sel_cnt_r[sel_sta_r]);
   assign rx_hit = letm_at_threshold(rx_any, rx_cnt_nxt); // RULE1
   assign tx_hit = letm_at_threshold(tx_any, tx_cnt_nxt); // RULE4
   assign sel_hit = letm_at_threshold(o_sel_timeout, sel_cnt_nxt); // RULE7

   // receive: an error outranks an error-free frame in the same cycle
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (k_rx = 0; k_rx < `LETM_NSTA; k_rx = k_rx + 1) begin
            rx_cnt_r[k_rx] <= `LETM_CNT_RST;
         end
      end else if (rx_hit) begin
         rx_cnt_r[i_rx_station] <= `LETM_CNT_RST; // RULE3 RULE12
      end else if (rx_any) begin
         rx_cnt_r[i_rx_station] <= rx_cnt_nxt; // RULE12
      end else if (i_rx_ok) begin
         rx_cnt_r[i_rx_station] <= `LETM_CNT_RST; // RULE13
      end
   end

   // transmit: start states keep the count so retries report every time
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (k_tx = 0; k_tx < `LETM_NSTA; k_tx = k_tx + 1) begin
            tx_cnt_r[k_tx] <= `LETM_CNT_RST;
         end
      end else if (tx_hit) begin
         tx_cnt_r[i_tx_station] <= i_tx_start_state ? tx_cnt_nxt : `LETM_CNT_RST; // RULE6
      end else if (tx_any) begin
         tx_cnt_r[i_tx_station] <= tx_cnt_nxt; // RULE12
      end else if (i_tx_ok) begin
         tx_cnt_r[i_tx_station] <= `LETM_CNT_RST; // RULE13
      end
   end

   // selection: counted against the station latched at window start
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (k_sel = 0; k_sel < `LETM_NSTA; k_sel = k_sel + 1) begin
            sel_cnt_r[k_sel] <= `LETM_CNT_RST;
         end
      end else if (sel_hit) begin
         sel_cnt_r[sel_sta_r] <= `LETM_CNT_RST; // RULE9
      end else if (o_sel_timeout) begin
         sel_cnt_r[sel_sta_r] <= sel_cnt_nxt; // RULE12
      end else if (sel_clear) begin
         sel_cnt_r[sel_sta_r] <= `LETM_CNT_RST; // RULE13
      end
   end

   // ---------------------------------------------------------------
   // response
   // ---------------------------------------------------------------
   // one report per cycle; lower code wins and the others are lost,
   // though their counters still clear, except a transmit count in start states, so the next run starts at zero
   always @* begin
      resp_valid_nxt = rx_hit || tx_hit || sel_hit;
      resp_type_nxt = o_response_type_byte;
      resp_addr_nxt = o_station_address_byte;
      if (rx_hit) begin
         resp_type_nxt = `LETM_CODE_RX; // RULE10
         resp_addr_nxt = letm_addr_byte(i_rx_station); // RULE11
      end else if (tx_hit) begin
         resp_type_nxt = `LETM_CODE_TX; // RULE10
         resp_addr_nxt = letm_addr_byte(i_tx_station); // RULE11
      end else if (sel_hit) begin
         resp_type_nxt = `LETM_CODE_SEL; // RULE10
         resp_addr_nxt = letm_addr_byte(sel_sta_r); // RULE11
      end
   end

   // bytes hold between reports so a slow host still reads the last one
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_resp_valid <= 1'b0;
         o_response_type_byte <= `LETM_BYTE_RST;
         o_station_address_byte <= `LETM_BYTE_RST;
      end else begin
         o_resp_valid <= resp_valid_nxt;
         o_response_type_byte <= resp_type_nxt;
         o_station_address_byte <= resp_addr_nxt;
      end
   end
endmodule
`default_nettype wire

// ==== dv/letm_link_model.sv ====
// letm_link_model.sv: far-side stations raising link events
// assumes bench calls hit, one event per cycle pair
`timescale 1ns/10ps
`default_nettype none
module letm_link_model (
   input wire logic i_clk,
   output logic [3:0] o_station,
   output logic [15:0] o_event
);
   initial {o_station, o_event} = '0;
   // o_event: 6:0 rx causes, 10:7 tx causes, 11 rx ok, 12 tx ok, 13 answer
   task automatic hit(input int k, input int w, input int c, input int s);
      for (int i = 0; i < c; i++) begin
         @(negedge i_clk) {o_station, o_event} = {4'(s), 16'h1 << (k + i % w)};
         @(negedge i_clk) o_event = '0;
      end
   endtask
endmodule
`default_nettype wire

// ==== dv/letm_monitor_sva.sv ====
// letm_monitor_sva.sv: assertions on the monitor ports
// assumes one clock and an async active low reset
`timescale 1ns/10ps
`default_nettype none
module letm_monitor_sva (input wire i_ref_clk, input wire i_nrst, input wire [3:0] i_rx_station,
   input wire [6:0] i_rx_err, input wire [3:0] i_tx_station, input wire [3:0] i_tx_err,
   input wire i_sel_begin, input wire i_sel_answer, input wire o_sel_timeout, input wire o_resp_valid,
   input wire [7:0] o_response_type_byte, input wire [7:0] o_station_address_byte);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   wire [7:0] t = o_response_type_byte;
   wire [7:0] a = o_station_address_byte;
   wire v = o_resp_valid;
   AST_TYPE: assert property (v |-> t inside {8'h02, 8'h04, 8'h06}) else $error("bad type");
   AST_RX: assert property (v && t == 8'h02 |-> $past(|i_rx_err)) else $error("rx cause");
   AST_TX: assert property (v && t == 8'h04 |-> $past(|i_tx_err)) else $error("tx cause");
   AST_SEL: assert property (v && t == 8'h06 |-> $past(o_sel_timeout)) else $error("sel cause");
   AST_RX_ADDR: assert property (v && t == 8'h02 |-> a == {4'h0, $past(i_rx_station)}) else $error("rx addr");
   AST_TX_ADDR: assert property (v && t == 8'h04 |-> a == {4'h0, $past(i_tx_station)}) else $error("tx addr");
   AST_HOLD: assert property (!v |-> $stable(t) && $stable(a)) else $error("bytes moved");
   AST_WIN: assert property (o_sel_timeout |-> !$past(i_sel_begin || i_sel_answer)) else $error("early");
   cover property (v && t == 8'h02);
   cover property (v && t == 8'h04);
   cover property (v && t == 8'h06);
endmodule
bind letm_monitor letm_monitor_sva i_letm_monitor_sva (.*);
`default_nettype wire

// ==== dv/test_link_error_threshold_monitor.sv ====
// test_link_error_threshold_monitor.sv: threshold report scenarios
// assumes monitor, link model and checker, 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "letm_defines.vh"
module test_link_error_threshold_monitor;
   logic clk = 0, nrst = 0, tx_st = 0, go = 0, tmo, vld;
   logic [3:0] st;
   logic [15:0] ev;
   logic [7:0] typ, adr, typ_r, adr_r;
   int err_total = 0, num_checks = 0, n = 0;
   initial forever #2 clk = ~clk;
   letm_link_model i_letm_link_model (.i_clk(clk), .o_station(st), .o_event(ev));
   letm_monitor i_letm_monitor (.i_ref_clk(clk), .i_nrst(nrst), .i_rx_station(st), .i_rx_ok(ev[11]),
      .i_rx_err(ev[6:0]), .i_tx_station(st), .i_tx_ok(ev[12]), .i_tx_err(ev[10:7]), .i_tx_start_state(tx_st),
      .i_sel_station(st), .i_sel_begin(go), .i_sel_answer(ev[13]), .o_sel_timeout(tmo), .o_resp_valid(vld),
      .o_response_type_byte(typ), .o_station_address_byte(adr));
   // sampled mid-cycle, where the one-cycle report has settled
   always @(negedge clk) if (vld === 1'b1) {n, typ_r, adr_r} = {n + 1, typ, adr};
   task automatic chk(string s, logic [7:0] g, logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic hit(int k, int w, int c, int s);
      i_letm_link_model.hit(k, w, c, s);
   endtask
   task automatic reply_request_message(int c, logic [7:0] t, logic [7:0] a);
      repeat (2) @(negedge clk);
      chk("reports", 8'(n), 8'(c));
      chk("type", typ_r, t);
      chk("addr", adr_r, a);
      n = 0;
   endtask
   // answered windows must never time out; 150 cycles bounds the wait
   task automatic win(logic a);
      int w = 0;
      @(negedge clk) go = 1;
      @(negedge clk) go = 0;
      if (a) hit(13, 1, 1, st);
      while (tmo !== 1'b1 && w < 150) begin
         @(negedge clk);
         w++;
      end
      chk("timeout", 8'(w < 150), 8'(!a));
      chk("window", 8'(w), a ? 8'd150 : 8'(`LETM_SEL_CYCLES - 1));
      if (!a && w == 150) close_out();
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk) nrst = 1;
      hit(0, 7, 7, 3);
      reply_request_message(1, 8'h02, 8'h03);
      hit(0, 7, 6, 3);
      hit(11, 1, 1, 3);
      hit(0, 7, 6, 3);
      reply_request_message(0, 8'h02, 8'h03);
      hit(7, 4, 6, 5);
      hit(7, 4, 6, 6);
      hit(7, 4, 1, 5);
      reply_request_message(1, 8'h04, 8'h05);
      hit(7, 4, 6, 5);
      reply_request_message(0, 8'h04, 8'h05);
      tx_st = 1;
      hit(7, 4, 8, 9);
      reply_request_message(2, 8'h04, 8'h09);
      tx_st = 0;
      hit(14, 1, 1, 7);
      win(1);
      repeat (7) win(0);
      reply_request_message(1, 8'h06, 8'h07);
      close_out();
   end
endmodule
`default_nettype wire
